// ==== verilog/wsr_pkg.sv ====
`default_nettype none
package wsr_pkg;
    localparam int unsigned SYS_CLK_MHZ = 250;
    // Internal RC oscillator step, modelled as a divider of the system clock
    localparam int unsigned RC_STEP_NS = 1000;
    localparam int unsigned RC_STEP_CYCLES = RC_STEP_NS * SYS_CLK_MHZ / 1000;
    localparam int unsigned WDT_PERIOD_US = 18_000;
    localparam int unsigned WDT_PERIOD_STEPS = WDT_PERIOD_US * 1000 / RC_STEP_NS;
    localparam int unsigned HOLD_PERIOD_US = 18_000;
    localparam int unsigned HOLD_PERIOD_STEPS = HOLD_PERIOD_US * 1000 / RC_STEP_NS;
    localparam int unsigned CNT_W = 24;
    localparam int unsigned QCLK_DIV_W = 2;

    localparam logic [3:0] ADDR_OPTION = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_FUSE = 4'h8;

    localparam int unsigned OPT_RATIO_LSB = 0;
    localparam int unsigned OPT_ASSIGN_BIT = 3;
    localparam logic [3:0] OPTION_RST = 4'hF;
    localparam int unsigned STAT_PWRDN_BIT = 3;
    localparam int unsigned STAT_TMO_BIT = 4;
    localparam int unsigned STAT_SLEEP_BIT = 0;

    localparam int unsigned FUSE_OSC_LSB = 0;
    localparam int unsigned FUSE_WDTE_BIT = 2;
    localparam int unsigned FUSE_CP_BIT = 3;
    localparam logic [3:0] FUSE_ERASED = 4'hF;
    localparam logic [1:0] OSC_RC = 2'h3;
    localparam logic [15:0] ID_ERASED = 16'hFFFF;
    localparam logic [10:0] CP_FREE_TOP = 11'h03F;
    localparam logic [15:0] PROTECTED_READ = 16'h0000;

    typedef enum logic [1:0] {
        SPACE_MEM = 2'b00,
        SPACE_ID = 2'b01,
        SPACE_FUSE = 2'b10
    } wsr_space_t;

    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_SLEEP = 2'b01,
        ST_CLEAR = 2'b10,
        ST_START = 2'b11
    } wsr_state_t;
endpackage
`default_nettype wire

// ==== verilog/wsr_watchdog.sv ====
`default_nettype none
module wsr_watchdog #(
    parameter int unsigned RC_DIV = wsr_pkg::RC_STEP_CYCLES,
    parameter int unsigned WDT_TICKS = wsr_pkg::WDT_PERIOD_STEPS,
    parameter int unsigned HOLD_TICKS = wsr_pkg::HOLD_PERIOD_STEPS,
    parameter int unsigned IO_W = 8,
    parameter bit SMALL_VARIANT = 1'b1,
    parameter bit WINDOWED = 1'b1
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic watchdog_clear_cmd,
    input wire logic sleep_cmd,
    input wire logic master_clear_in,
    input wire logic [IO_W-1:0] core_io_out,
    input wire logic [IO_W-1:0] core_io_oe,
    output logic [IO_W-1:0] io_out,
    output logic [IO_W-1:0] io_oe,
    output logic device_reset,
    output logic main_osc_enable,
    output logic quarter_clock_out,
    output logic timeout_flag,
    output logic powerdown_flag,
    input wire logic prog_write,
    input wire logic prog_read,
    input wire logic [1:0] prog_space,
    input wire logic [10:0] prog_addr,
    input wire logic [15:0] prog_wdata,
    input wire logic [15:0] mem_rdata,
    output logic mem_write_en,
    output logic prog_ack,
    output logic prog_nak,
    output logic prog_rvalid,
    output logic [15:0] prog_rdata
);
    localparam int unsigned CW = wsr_pkg::CNT_W;
    localparam logic [CW-1:0] WDT_LAST = CW'(WDT_TICKS - 1);
    localparam logic [CW-1:0] WDT_HALF = CW'(WDT_TICKS / 2);
    localparam logic [CW-1:0] HOLD_LAST = CW'(HOLD_TICKS - 1);
    localparam logic [15:0] RC_LAST = 16'(RC_DIV - 1);

    if (WDT_TICKS < 2 || HOLD_TICKS < 1 || WDT_TICKS >= (1 << CW) || HOLD_TICKS >= (1 << CW)
        || RC_DIV < 1 || RC_DIV > 65536 || IO_W < 1) begin : g_bad
        $error("wsr_watchdog: parameter out of range");
    end

    wsr_pkg::wsr_state_t state;
    logic pin_meta;
    logic pin_sync;
    logic [15:0] rc_div;
    logic rc_tick;
    logic [6:0] pre_cnt;
    logic [CW-1:0] wdt_cnt;
    logic [CW-1:0] hold_cnt;
    logic [3:0] option;
    logic [3:0] fuse;
    logic [15:0] user_id;
    logic [wsr_pkg::QCLK_DIV_W-1:0] qclk_div;
    logic ack;

    logic wdt_en;
    logic code_prot;
    logic psa;
    logic [6:0] pre_last;
    logic wdt_step;
    logic active;
    logic cmd_clr;
    logic cmd_sleep;
    logic late_cmd;
    logic timeout;
    logic fire;
    logic pin_low;
    logic hold_done;
    logic wr_ok;
    logic [3:0] fuse_mask;

    assign wdt_en = fuse[wsr_pkg::FUSE_WDTE_BIT];
    assign code_prot = !fuse[wsr_pkg::FUSE_CP_BIT];
    assign psa = option[wsr_pkg::OPT_ASSIGN_BIT];
    assign pre_last = 7'((8'h01 << option[wsr_pkg::OPT_RATIO_LSB +: 3]) - 8'h01);
    assign pin_low = !pin_sync;
    assign active = (state == wsr_pkg::ST_RUN) && !pin_low;
    assign cmd_clr = active && watchdog_clear_cmd && !sleep_cmd;
    assign cmd_sleep = active && sleep_cmd;
    assign wdt_step = rc_tick && (!psa || pre_cnt == pre_last);
    // Clear and step in one cycle: the clear masks the timeout; with SMALL_VARIANT and no prescaler late_cmd still fires
    assign timeout = wdt_en && wdt_step && (wdt_cnt == WDT_LAST) && !cmd_clr && !cmd_sleep
        && !pin_low && (state == wsr_pkg::ST_RUN || state == wsr_pkg::ST_SLEEP);
    assign late_cmd = SMALL_VARIANT && wdt_en && !psa && (cmd_clr || cmd_sleep)
        && (wdt_cnt >= WDT_HALF);
    assign fire = timeout || late_cmd;
    assign hold_done = rc_tick && (hold_cnt == HOLD_LAST);
    assign device_reset = (state == wsr_pkg::ST_CLEAR) || (state == wsr_pkg::ST_START);
    assign main_osc_enable = (state != wsr_pkg::ST_SLEEP);
    assign avs_waitrequest = (avs_read || avs_write) && !ack;

    // Master clear is an asynchronous pin
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pin_meta <= 1'b1;
            pin_sync <= 1'b1;
        end else begin
            pin_meta <= master_clear_in;
            pin_sync <= pin_meta;
        end
    end

    // Free-running RC step, never stopped by sleep or device reset
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rc_div <= 16'h0000;
            rc_tick <= 1'b0;
        end else begin
            rc_tick <= (rc_div == RC_LAST);
            rc_div <= (rc_div == RC_LAST) ? 16'h0000 : rc_div + 16'h0001;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state <= wsr_pkg::ST_START;
        end else if (pin_low) begin
            state <= wsr_pkg::ST_CLEAR;
        end else begin
            unique case (state)
                wsr_pkg::ST_RUN: begin
                    if (fire) begin
                        state <= wsr_pkg::ST_START;
                    end else if (cmd_sleep) begin
                        state <= wsr_pkg::ST_SLEEP;
                    end
                end
                wsr_pkg::ST_SLEEP: begin
                    if (fire) begin
                        state <= wsr_pkg::ST_START;
                    end
                end
                wsr_pkg::ST_CLEAR: begin
                    state <= wsr_pkg::ST_START;
                end
                wsr_pkg::ST_START: begin
                    if (hold_done) begin
                        state <= wsr_pkg::ST_RUN;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset || state != wsr_pkg::ST_START || pin_low) begin
            hold_cnt <= '0;
        end else if (rc_tick) begin
            hold_cnt <= hold_done ? '0 : hold_cnt + CW'(1);
        end
    end

    // Counter keeps running through sleep; held at zero while disabled or in reset
    always_ff @(posedge sys_clk) begin
        if (reset || !wdt_en || device_reset || fire) begin
            wdt_cnt <= '0;
            pre_cnt <= 7'h00;
        end else if (cmd_clr || cmd_sleep) begin
            wdt_cnt <= '0;
            if (psa) begin
                pre_cnt <= 7'h00;
            end
        end else if (rc_tick) begin
            if (psa) begin
                pre_cnt <= (pre_cnt == pre_last) ? 7'h00 : pre_cnt + 7'h01;
            end
            if (wdt_step) begin
                wdt_cnt <= wdt_cnt + CW'(1);
            end
        end
    end

    // Fire (timeout or late command) beats a command in the same cycle, so the cause is never lost
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            timeout_flag <= 1'b1;
            powerdown_flag <= 1'b1;
        end else if (fire) begin
            timeout_flag <= 1'b0;
        end else if (cmd_sleep) begin
            timeout_flag <= 1'b1;
            powerdown_flag <= 1'b0;
        end else if (cmd_clr) begin
            timeout_flag <= 1'b1;
            powerdown_flag <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            io_out <= '0;
            io_oe <= '0;
        end else if (state != wsr_pkg::ST_SLEEP) begin
            io_out <= core_io_out;
            io_oe <= core_io_oe;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset || !main_osc_enable) begin
            qclk_div <= '0;
            quarter_clock_out <= 1'b0;
        end else begin
            qclk_div <= qclk_div + 2'(1);
            quarter_clock_out <= (fuse[wsr_pkg::FUSE_OSC_LSB +: 2] == wsr_pkg::OSC_RC)
                && qclk_div[1];
        end
    end

    // One wait cycle, then the answer; unmapped reads return zero, writes are dropped
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ack <= 1'b0;
            option <= wsr_pkg::OPTION_RST;
            avs_readdata <= 32'h0000_0000;
        end else begin
            ack <= (avs_read || avs_write) && !ack;
            if (avs_write && !ack && avs_address == wsr_pkg::ADDR_OPTION) begin
                option <= avs_writedata[3:0];
            end
            if (avs_read && !ack) begin
                avs_readdata <= 32'h0000_0000;
                unique case (avs_address)
                    wsr_pkg::ADDR_OPTION: avs_readdata[3:0] <= option;
                    wsr_pkg::ADDR_STATUS: begin
                        avs_readdata[wsr_pkg::STAT_TMO_BIT] <= timeout_flag;
                        avs_readdata[wsr_pkg::STAT_PWRDN_BIT] <= powerdown_flag;
                        avs_readdata[wsr_pkg::STAT_SLEEP_BIT] <= !main_osc_enable;
                    end
                    wsr_pkg::ADDR_FUSE: avs_readdata[3:0] <= fuse;
                    default: avs_readdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Fuses under protection: watchdog and protect fuse writable, oscillator pair only if windowed
    assign fuse_mask = code_prot ? {2'b11, WINDOWED ? 2'b11 : 2'b00} : 4'hF;
    always_comb begin
        wr_ok = 1'b1;
        if (prog_space == wsr_pkg::SPACE_MEM) begin
            wr_ok = !code_prot || (prog_addr <= wsr_pkg::CP_FREE_TOP);
        end else if (prog_space != wsr_pkg::SPACE_ID && prog_space != wsr_pkg::SPACE_FUSE) begin
            wr_ok = 1'b0;
        end
    end

    // One-time cells: programming only turns ones into zeros
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            fuse <= wsr_pkg::FUSE_ERASED;
            user_id <= wsr_pkg::ID_ERASED;
            mem_write_en <= 1'b0;
            prog_ack <= 1'b0;
            prog_nak <= 1'b0;
            prog_rvalid <= 1'b0;
            prog_rdata <= 16'h0000;
        end else begin
            mem_write_en <= prog_write && wr_ok && prog_space == wsr_pkg::SPACE_MEM;
            prog_ack <= prog_write && wr_ok;
            prog_nak <= prog_write && !wr_ok;
            prog_rvalid <= prog_read && !prog_write;
            if (prog_write && wr_ok && prog_space == wsr_pkg::SPACE_ID) begin
                user_id <= user_id & prog_wdata;
            end
            if (prog_write && wr_ok && prog_space == wsr_pkg::SPACE_FUSE) begin
                fuse <= fuse & (prog_wdata[3:0] | ~fuse_mask);
            end
            if (prog_read && !prog_write) begin
                unique case (prog_space)
                    wsr_pkg::SPACE_ID: prog_rdata <= user_id;
                    wsr_pkg::SPACE_FUSE: prog_rdata <= {12'h000, fuse};
                    wsr_pkg::SPACE_MEM: prog_rdata <= code_prot ? wsr_pkg::PROTECTED_READ
                        : mem_rdata;
                    default: prog_rdata <= 16'h0000;
                endcase
            end
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);

    timeout_reset_a: assert property (fire && !pin_low |=> state == wsr_pkg::ST_START && device_reset)
        else $error("timeout did not start reset hold");
    timeout_flag_a: assert property (fire |=> !timeout_flag)
        else $error("timeout flag not cleared on timeout");
    disabled_wdt_a: assert property (!wdt_en |-> !timeout ##1 wdt_cnt == '0)
        else $error("disabled watchdog still counting");
    late_clear_a: assert property (SMALL_VARIANT && active && watchdog_clear_cmd && !psa
        && wdt_en && wdt_cnt >= WDT_HALF |=> state == wsr_pkg::ST_START)
        else $error("late clear did not reset");
    prescaled_clear_a: assert property (active && watchdog_clear_cmd && !sleep_cmd && psa
        |=> state == wsr_pkg::ST_RUN && wdt_cnt == '0)
        else $error("prescaled clear caused reset");
    sleep_entry_a: assert property (cmd_sleep && !fire |=> !powerdown_flag
        && timeout_flag && wdt_cnt == '0 && !main_osc_enable)
        else $error("sleep entry effects wrong");
    io_hold_a: assert property (state == wsr_pkg::ST_SLEEP ##1 state == wsr_pkg::ST_SLEEP
        |-> $stable(io_out) && $stable(io_oe))
        else $error("io changed during sleep");
    hold_length_a: assert property ($fell(device_reset) |-> $past(hold_cnt) == HOLD_LAST)
        else $error("start-up hold length wrong");
    cp_block_a: assert property (prog_write && prog_space == wsr_pkg::SPACE_MEM && code_prot
        && prog_addr > wsr_pkg::CP_FREE_TOP |=> prog_nak && !prog_ack && !mem_write_en)
        else $error("protected location programmed");
    fuse_read_a: assert property (prog_read && !prog_write && prog_space == wsr_pkg::SPACE_FUSE
        |=> prog_rvalid && prog_rdata[3:0] == $past(fuse))
        else $error("fuse readback wrong");

    wdt_wake_c: cover property (state == wsr_pkg::ST_SLEEP && fire);
    pin_wake_c: cover property (state == wsr_pkg::ST_SLEEP ##1 state == wsr_pkg::ST_CLEAR);
    late_clear_c: cover property (late_cmd && cmd_clr);
    option_write_c: cover property (avs_write && !avs_waitrequest);
endmodule
`default_nettype wire

// ==== sim/wsr_core_model.sv ====
`default_nettype none
module wsr_core_model #(
    parameter int IO_W = 8
) (
    input wire logic sys_clk,
    input wire logic device_reset,
    output logic watchdog_clear_cmd,
    output logic sleep_cmd,
    output logic [IO_W-1:0] core_io_out,
    output logic [IO_W-1:0] core_io_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        watchdog_clear_cmd = 1'b0;
        sleep_cmd = 1'b0;
        core_io_out = '0;
        core_io_oe = '0;
    end
    // A core held in reset executes nothing, so no command leaves it then
    task automatic issue(input bit slp, input int delay);
        repeat (delay) @(posedge sys_clk);
        if (device_reset === 1'b0) begin
            if (slp) begin
                sleep_cmd <= 1'b1;
            end else begin
                watchdog_clear_cmd <= 1'b1;
            end
            @(posedge sys_clk);
            sleep_cmd <= 1'b0;
            watchdog_clear_cmd <= 1'b0;
        end
        // One idle edge so a following command never rewrites a strobe in the same step
        @(posedge sys_clk);
    endtask
    task automatic drive_io(input logic [IO_W-1:0] val, input logic [IO_W-1:0] oe);
        core_io_out <= val;
        core_io_oe <= oe;
    endtask
endmodule
`default_nettype wire

// ==== sim/test_watchdog_sleep_wake_reset.sv ====
`default_nettype none
module test_watchdog_sleep_wake_reset;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int RCD = 2;
    localparam int WT = 64;
    localparam int OT = 16;
    localparam int HLO = OT * RCD - 4;
    localparam int HHI = OT * RCD + 10;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic [3:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = '0;
    logic [31:0] avs_readdata, rd;
    logic avs_waitrequest, watchdog_clear_cmd, sleep_cmd, device_reset, main_osc_enable;
    logic master_clear_in = 1'b1;
    logic [7:0] core_io_out, core_io_oe, io_out, io_oe;
    logic quarter_clock_out, timeout_flag, powerdown_flag, prev;
    logic prog_write = 1'b0;
    logic prog_read = 1'b0;
    logic [1:0] prog_space = '0;
    logic [10:0] prog_addr = '0;
    logic [15:0] prog_wdata = '0;
    logic [15:0] mem_rdata = 16'h1234;
    logic mem_write_en, prog_ack, prog_nak, prog_rvalid;
    logic [15:0] prog_rdata, r, id_exp;
    int fails = 0;
    int n_tests = 0;
    int cyc = 0;
    int n;

    always #2 sys_clk = ~sys_clk;

    wsr_watchdog #(.RC_DIV(RCD), .WDT_TICKS(WT), .HOLD_TICKS(OT)) u_dut (
        .sys_clk(sys_clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .watchdog_clear_cmd(watchdog_clear_cmd),
        .sleep_cmd(sleep_cmd), .master_clear_in(master_clear_in), .core_io_out(core_io_out),
        .core_io_oe(core_io_oe), .io_out(io_out), .io_oe(io_oe), .device_reset(device_reset),
        .main_osc_enable(main_osc_enable), .quarter_clock_out(quarter_clock_out),
        .timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag), .prog_write(prog_write),
        .prog_read(prog_read), .prog_space(prog_space), .prog_addr(prog_addr),
        .prog_wdata(prog_wdata), .mem_rdata(mem_rdata), .mem_write_en(mem_write_en),
        .prog_ack(prog_ack), .prog_nak(prog_nak), .prog_rvalid(prog_rvalid),
        .prog_rdata(prog_rdata));

    wsr_core_model #(.IO_W(8)) core (
        .sys_clk(sys_clk), .device_reset(device_reset), .watchdog_clear_cmd(watchdog_clear_cmd),
        .sleep_cmd(sleep_cmd), .core_io_out(core_io_out), .core_io_oe(core_io_oe));

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            fails++;
            conclude();
        end
    end

    task automatic bus(input bit wr, input logic [3:0] a, input logic [31:0] d);
        int k;
        k = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        do begin
            @(posedge sys_clk);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 50);
        // Read data is taken at the same edge that sees waitrequest low
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge sys_clk);
        check("bus_answer", 32'(k < 50), 32'h0000_0001);
    endtask

    task automatic prog(input bit wr, input logic [1:0] sp, input logic [10:0] a,
                        input logic [15:0] d, input bit ok);
        prog_write <= wr;
        prog_read <= !wr;
        prog_space <= sp;
        prog_addr <= a;
        prog_wdata <= d;
        @(posedge sys_clk);
        prog_write <= 1'b0;
        prog_read <= 1'b0;
        @(negedge sys_clk);
        // Reads answer with rvalid only; ack and nak belong to writes
        check("prog_ack", 32'(prog_ack), 32'(wr && ok));
        check("prog_nak", 32'(prog_nak), 32'(wr && !ok));
        if (wr && sp == 2'h0) check("mem_write_en", 32'(mem_write_en), 32'(ok));
        if (!wr) check("prog_rvalid", 32'(prog_rvalid), 32'(ok));
        @(posedge sys_clk);
    endtask

    // Counts cycles until device_reset reaches lvl and checks the count lies in [lo, hi]
    task automatic span(input logic lvl, input int lo, input int hi, input string what);
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while (device_reset !== lvl && n < hi + 20);
        @(posedge sys_clk);
        check(what, 32'(n >= lo && n <= hi), 32'h0000_0001);
    endtask

    task automatic quiet(input int c, input string what);
        int bad;
        bad = 0;
        repeat (c) begin
            @(negedge sys_clk);
            if (device_reset !== 1'b0) bad++;
        end
        @(posedge sys_clk);
        check(what, 32'(bad), 32'h0000_0000);
    endtask

    task automatic stat(input logic to, input logic pd);
        bus(1'b0, 4'h4, 32'h0000_0000);
        check("status_timeout", 32'(rd[4]), 32'(to));
        check("status_powerdown", 32'(rd[3]), 32'(pd));
        check("timeout_flag", 32'(timeout_flag), 32'(to));
        check("powerdown_flag", 32'(powerdown_flag), 32'(pd));
    endtask

    initial begin
        void'($urandom(58));
        id_exp = 16'hFFFF;
        repeat (5) @(posedge sys_clk);
        reset <= 1'b0;
        span(1'b0, HLO, HHI, "por_hold");
        stat(1'b1, 1'b1);
        bus(1'b0, 4'h0, 32'h0000_0000);
        check("option_rst", rd, 32'h0000_000F);
        bus(1'b0, 4'h8, 32'h0000_0000);
        check("fuse_rst", rd, 32'h0000_000F);
        bus(1'b1, 4'h4, 32'h0000_0000);
        bus(1'b0, 4'hC, 32'h0000_0000);
        check("unmapped", rd, 32'h0000_0000);
        stat(1'b1, 1'b1);
        @(negedge sys_clk);
        prev = quarter_clock_out;
        n = 0;
        repeat (16) begin
            @(negedge sys_clk);
            if (quarter_clock_out === 1'b1 && prev === 1'b0) n++;
            prev = quarter_clock_out;
        end
        @(posedge sys_clk);
        check("quarter_clock", 32'(n), 32'h0000_0004);
        bus(1'b1, 4'h0, 32'h0000_0000);
        bus(1'b0, 4'h0, 32'h0000_0000);
        check("option_wr", rd, 32'h0000_0000);
        core.issue(1'b0, 0);
        for (int i = 0; i < 6; i++) begin
            quiet(20 + int'($urandom % 30), "early_clear");
            core.issue(1'b0, 0);
        end
        quiet(40 * RCD, "late_wait");
        core.issue(1'b0, 0);
        span(1'b1, 1, 3, "late_clear");
        span(1'b0, HLO, HHI, "late_hold");
        stat(1'b0, 1'b1);
        bus(1'b1, 4'h0, 32'h0000_0000);
        core.issue(1'b0, 0);
        span(1'b1, (WT - 2) * RCD, (WT + 2) * RCD + 4, "timeout");
        span(1'b0, HLO, HHI, "timeout_hold");
        stat(1'b0, 1'b1);
        bus(1'b1, 4'h0, 32'h0000_0008);
        core.issue(1'b0, 0);
        quiet(50 * RCD, "prescaled_clear");
        core.issue(1'b0, 0);
        bus(1'b1, 4'h0, 32'h0000_0009);
        core.issue(1'b0, 0);
        span(1'b1, (2 * WT - 4) * RCD, (2 * WT + 4) * RCD + 4, "ratio_two");
        span(1'b0, HLO, HHI, "ratio_hold");
        bus(1'b1, 4'h0, 32'h0000_0000);
        r = 16'($urandom);
        core.drive_io(r[7:0], r[15:8]);
        core.issue(1'b0, 0);
        core.issue(1'b1, 2);
        @(negedge sys_clk);
        check("osc_off", 32'(main_osc_enable), 32'h0000_0000);
        @(posedge sys_clk);
        core.drive_io(~r[7:0], ~r[15:8]);
        stat(1'b1, 1'b0);
        check("sleeping", 32'(rd[0]), 32'h0000_0001);
        check("io_out", 32'(io_out), 32'(r[7:0]));
        check("io_oe", 32'(io_oe), 32'(r[15:8]));
        check("qclk_sleep", 32'(quarter_clock_out), 32'h0000_0000);
        span(1'b1, (WT - 8) * RCD, (WT + 2) * RCD + 4, "sleep_wake");
        span(1'b0, HLO, HHI, "wake_hold");
        stat(1'b0, 1'b0);
        bus(1'b1, 4'h0, 32'h0000_0000);
        core.issue(1'b0, 0);
        core.issue(1'b1, 2);
        quiet(20, "asleep");
        master_clear_in <= 1'b0;
        span(1'b1, 1, 5, "pin_wake");
        repeat (3) @(posedge sys_clk);
        master_clear_in <= 1'b1;
        span(1'b0, HLO, HHI + 2, "pin_hold");
        stat(1'b1, 1'b0);
        prog(1'b0, 2'h2, 11'h000, 16'h0000, 1'b1);
        check("fuse_read", 32'(prog_rdata[3:0]), 32'h0000_000F);
        for (int i = 0; i < 2; i++) begin
            r = 16'($urandom);
            id_exp = id_exp & r;
            prog(1'b1, 2'h1, 11'h000, r, 1'b1);
            prog(1'b0, 2'h1, 11'h000, 16'h0000, 1'b1);
            check("id_read", 32'(prog_rdata), 32'(id_exp));
            if (i == 0) prog(1'b1, 2'h2, 11'h000, 16'h0003, 1'b1);
        end
        bus(1'b0, 4'h8, 32'h0000_0000);
        check("fuse_after", 32'(rd[3:0]), 32'h0000_0003);
        prog(1'b1, 2'h0, 11'h040, 16'(~r), 1'b0);
        prog(1'b1, 2'h0, 11'h040 + 11'($urandom % 1984), r, 1'b0);
        prog(1'b1, 2'h0, 11'h03F, r, 1'b1);
        prog(1'b1, 2'h0, 11'($urandom % 64), r, 1'b1);
        mem_rdata <= 16'($urandom) | 16'h0001;
        prog(1'b0, 2'h0, 11'h010, 16'h0000, 1'b1);
        check("mem_hidden", 32'(prog_rdata), 32'h0000_0000);
        prog(1'b1, 2'h2, 11'h000, 16'h0001, 1'b1);
        prog(1'b1, 2'h3, 11'h000, 16'h0000, 1'b0);
        bus(1'b1, 4'h0, 32'h0000_0000);
        core.issue(1'b0, 0);
        quiet(400, "wdt_off");
        conclude();
    end
endmodule
`default_nettype wire
